// ### ssu_rank.sv
// shift unit constants package and one shift rank
`default_nettype none

package ssu_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SSU_DW = 60;
    localparam int SSU_CW = 6;
    localparam int SSU_AW = 8;
    localparam int SSU_BW = 32;
    localparam int SSU_IW = 15;
    localparam int SSU_HI_W = SSU_DW - SSU_BW;
    localparam int SSU_IDX_W_DEF = 18;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SSU_A_INSTR = 8'h00;
    localparam logic [7:0] SSU_A_DEST_LO = 8'h04;
    localparam logic [7:0] SSU_A_DEST_HI = 8'h08;
    localparam logic [7:0] SSU_A_ALT_LO = 8'h0c;
    localparam logic [7:0] SSU_A_ALT_HI = 8'h10;
    localparam logic [7:0] SSU_A_INDEX = 8'h14;
    localparam logic [7:0] SSU_A_CTRL = 8'h18;
    localparam logic [7:0] SSU_A_STAT = 8'h1c;
    // ------------------------------------------------------------
    // instruction word fields: f m i j k, three bits each
    // ------------------------------------------------------------
    localparam int SSU_F_LSB = 12;
    localparam int SSU_M_LSB = 9;
    localparam int SSU_J_LSB = 3;
    localparam int SSU_K_LSB = 0;
    localparam int SSU_D_W = 3;
    localparam int SSU_F_MID = 1;
    localparam int SSU_M_DIR = 0;
    localparam int SSU_M_NOM = 1;
    // ------------------------------------------------------------
    // control and status bits
    // ------------------------------------------------------------
    localparam int SSU_CTRL_GO = 0;
    localparam int SSU_ST_BUSY = 0;
    localparam int SSU_ST_DONE = 1;
    localparam int SSU_ST_COMP = 2;
    localparam int SSU_ST_LCS = 3;
    localparam int SSU_ST_OVER = 4;
    // ------------------------------------------------------------
    // shift geometry
    // ------------------------------------------------------------
    localparam int SSU_PRE_ROT = 3;
    localparam int SSU_STEP1 = 1;
    localparam int SSU_STEP2 = 4;
    localparam int SSU_STEP3 = 16;
    localparam int SSU_NSEL = 4;
    localparam logic [SSU_NSEL-1:0] SSU_SEL_ONE = 4'h1;
    localparam logic [31:0] SSU_WORD_ZERO = 32'h0000_0000;

    typedef enum logic [0:0] {SSU_IDLE, SSU_SHIFT} ssu_state_t;
endpackage

module ssu_rank
    import ssu_pkg::*;
#(
    parameter int W = SSU_DW,
    parameter int STEP = SSU_STEP1
) (
    input wire logic [W-1:0] i_data,
    input wire logic [SSU_NSEL-1:0] i_sel,
    input wire logic i_circ,
    output logic [W-1:0] o_data
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if ((SSU_NSEL - 1) * STEP >= W || STEP < 1) begin : g_bad
        $error("ssu_rank: step too large for width");
    end

    // ------------------------------------------------------------
    // one term per flag, or-ed; no flag gives zeros
    // ------------------------------------------------------------
    logic [W-1:0] part [SSU_NSEL];
    genvar g;
    for (g = 0; g < SSU_NSEL; g++) begin : g_amt
        localparam int N = g * STEP;
        if (N == 0) begin : g_zero
            assign part[g] = i_sel[g] ? i_data : '0;
        end else begin : g_move
            logic [W-1:0] wrap;
            assign wrap = i_circ ? (i_data << (W - N)) : '0;
            assign part[g] = i_sel[g] ? ((i_data >> N) | wrap) : '0;
        end
    end

    always_comb begin
        o_data = '0;
        for (int n = 0; n < SSU_NSEL; n++) begin
            o_data = o_data | part[n];
        end
    end
endmodule

`default_nettype wire

// ### ssu_unit.sv
// sixty bit shift and mask unit with its register slave
`default_nettype none

module ssu_unit
    import ssu_pkg::*;
#(
    parameter int IDX_W = SSU_IDX_W_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [SSU_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [SSU_BW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [SSU_BW-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [SSU_DW-1:0] o_result,
    output logic o_busy
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (IDX_W <= SSU_CW || IDX_W > SSU_BW) begin : g_bad
        $error("ssu_unit: index width out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ssu_state_t state, next_state;
    logic [SSU_IW-1:0] instr_word_reg, next_instr_word_reg;
    logic [SSU_DW-1:0] dest_operand_reg, next_dest_operand_reg;
    logic [SSU_DW-1:0] alt_operand_reg, next_alt_operand_reg;
    logic [IDX_W-1:0] index_count_reg, next_index_count_reg;
    logic [SSU_DW-1:0] hold, next_hold;
    logic comp_flag, next_comp_flag;
    logic lcs_flag, next_lcs_flag;
    logic over_flag, next_over_flag;
    logic [SSU_NSEL-1:0] sel1, next_sel1;
    logic [SSU_NSEL-1:0] sel2, next_sel2;
    logic [SSU_NSEL-1:0] sel3, next_sel3;
    logic done, next_done;
    logic rd_ack, next_rd_ack;
    logic [SSU_BW-1:0] rd_data, next_rd_data;

    // ------------------------------------------------------------
    // byte lane merge
    // ------------------------------------------------------------
    function automatic logic [SSU_BW-1:0] ssu_merge(input logic [SSU_BW-1:0] old,
                                                   input logic [SSU_BW-1:0] wd,
                                                   input logic [3:0] be);
        logic [SSU_BW-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // instruction translation
    // ------------------------------------------------------------
    logic [SSU_D_W-1:0] f_des, m_des;
    logic is_mask, nominal, idx_neg, go_left, cnt_cmp, over, op_neg;
    logic [SSU_CW-1:0] cnt_raw, cnt;
    logic [IDX_W-1:0] idx_eff;
    logic [SSU_DW-1:0] operand, pre;

    assign f_des = instr_word_reg[SSU_F_LSB +: SSU_D_W];
    assign m_des = instr_word_reg[SSU_M_LSB +: SSU_D_W];
    assign is_mask = ~f_des[SSU_F_MID];
    assign nominal = m_des[SSU_M_NOM] & ~is_mask;
    assign idx_neg = index_count_reg[IDX_W-1];
    // fixed: m bit 0 clear is left; nominal: sign flips the direction
    assign go_left = ~is_mask & (nominal ? ~(m_des[SSU_M_DIR] ^ idx_neg)
                                         : ~m_des[SSU_M_DIR]);

    // ------------------------------------------------------------
    // shift count selection
    // ------------------------------------------------------------
    assign cnt_raw = nominal ? index_count_reg[SSU_CW-1:0]
                             : {instr_word_reg[SSU_J_LSB +: SSU_D_W],
                                instr_word_reg[SSU_K_LSB +: SSU_D_W]};
    // any shift with m bit 0 clear (20, 22) complements; 23 with a negative index keeps it as is
    assign cnt_cmp = ~is_mask & ~m_des[SSU_M_DIR];
    assign cnt = cnt_cmp ? ~cnt_raw : cnt_raw;
    assign idx_eff = cnt_cmp ? ~index_count_reg : index_count_reg;
    assign over = nominal & ~go_left & (|idx_eff[IDX_W-1:SSU_CW]);

    // ------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------
    assign operand = m_des[SSU_M_NOM] ? alt_operand_reg : dest_operand_reg;
    assign op_neg = operand[SSU_DW-1];

    always_comb begin
        if (is_mask) begin
            pre = '0;
        end else if (go_left) begin
            pre = {operand[SSU_DW-1-SSU_PRE_ROT:0],
                   operand[SSU_DW-1 -: SSU_PRE_ROT]};
        end else begin
            pre = operand;
        end
    end

    // ------------------------------------------------------------
    // shift ranks
    // ------------------------------------------------------------
    logic [SSU_DW-1:0] rank1_in, rank1_out, rank2_out, rank3_out;
    logic [SSU_DW-1:0] shift_bus, result;
    logic go_shift;

    // mask: zeros inverted become the forced ones
    assign rank1_in = comp_flag ? ~hold : hold;

    // each rank feeds the next, so amounts add
    ssu_rank #(.W(SSU_DW), .STEP(SSU_STEP1)) u_rank1 (
        .i_data(rank1_in),
        .i_sel(sel1),
        .i_circ(lcs_flag),
        .o_data(rank1_out)
    );
    ssu_rank #(.W(SSU_DW), .STEP(SSU_STEP2)) u_rank2 (
        .i_data(rank1_out),
        .i_sel(sel2),
        .i_circ(lcs_flag),
        .o_data(rank2_out)
    );
    ssu_rank #(.W(SSU_DW), .STEP(SSU_STEP3)) u_rank3 (
        .i_data(rank2_out),
        .i_sel(sel3),
        .i_circ(lcs_flag),
        .o_data(rank3_out)
    );

    assign go_shift = (state == SSU_SHIFT);
    assign shift_bus = go_shift ? ~rank3_out : '1;
    // positive operands were inverted once only; over-range forces zeros
    assign result = (~comp_flag | over_flag) ? ~shift_bus : shift_bus;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic busy, wr_ok, rd_go;
    logic [SSU_BW-1:0] rd_mux, stat_word;

    assign busy = (state != SSU_IDLE);
    assign wr_ok = i_clk_en & i_avs_write & ~busy;
    assign rd_go = i_clk_en & i_avs_read & ~rd_ack;
    assign o_avs_waitrequest = ~i_clk_en | (i_avs_read & ~rd_ack) | (i_avs_write & busy);
    assign o_avs_readdata = rd_data;
    assign o_result = dest_operand_reg;
    assign o_busy = busy;

    always_comb begin
        stat_word = SSU_WORD_ZERO;
        stat_word[SSU_ST_BUSY] = busy;
        stat_word[SSU_ST_DONE] = done;
        stat_word[SSU_ST_COMP] = comp_flag;
        stat_word[SSU_ST_LCS] = lcs_flag;
        stat_word[SSU_ST_OVER] = over_flag;
    end

    always_comb begin
        rd_mux = SSU_WORD_ZERO;
        if (i_avs_address == SSU_A_INSTR) begin
            rd_mux[SSU_IW-1:0] = instr_word_reg;
        end else if (i_avs_address == SSU_A_DEST_LO) begin
            rd_mux = dest_operand_reg[SSU_BW-1:0];
        end else if (i_avs_address == SSU_A_DEST_HI) begin
            rd_mux[SSU_HI_W-1:0] = dest_operand_reg[SSU_DW-1:SSU_BW];
        end else if (i_avs_address == SSU_A_ALT_LO) begin
            rd_mux = alt_operand_reg[SSU_BW-1:0];
        end else if (i_avs_address == SSU_A_ALT_HI) begin
            rd_mux[SSU_HI_W-1:0] = alt_operand_reg[SSU_DW-1:SSU_BW];
        end else if (i_avs_address == SSU_A_INDEX) begin
            rd_mux[IDX_W-1:0] = index_count_reg;
        end else if (i_avs_address == SSU_A_STAT) begin
            rd_mux = stat_word;
        end
    end

    // ------------------------------------------------------------
    // register and sequence next values
    // ------------------------------------------------------------
    logic [SSU_BW-1:0] m_word;
    logic go_cmd;

    always_comb begin
        next_state = state;
        next_instr_word_reg = instr_word_reg;
        next_dest_operand_reg = dest_operand_reg;
        next_alt_operand_reg = alt_operand_reg;
        next_index_count_reg = index_count_reg;
        next_hold = hold;
        next_comp_flag = comp_flag;
        next_lcs_flag = lcs_flag;
        next_over_flag = over_flag;
        next_sel1 = sel1;
        next_sel2 = sel2;
        next_sel3 = sel3;
        next_done = done;
        next_rd_ack = i_avs_read & ~rd_ack;
        next_rd_data = rd_go ? rd_mux : rd_data;
        m_word = SSU_WORD_ZERO;
        go_cmd = 1'b0;
        if (wr_ok) begin
            if (i_avs_address == SSU_A_INSTR) begin
                m_word = ssu_merge({{(SSU_BW-SSU_IW){1'b0}}, instr_word_reg},
                                   i_avs_writedata, i_avs_byteenable);
                next_instr_word_reg = m_word[SSU_IW-1:0];
            end else if (i_avs_address == SSU_A_DEST_LO) begin
                next_dest_operand_reg[SSU_BW-1:0] = ssu_merge(
                    dest_operand_reg[SSU_BW-1:0], i_avs_writedata, i_avs_byteenable);
            end else if (i_avs_address == SSU_A_DEST_HI) begin
                m_word = ssu_merge({{(SSU_BW-SSU_HI_W){1'b0}},
                                    dest_operand_reg[SSU_DW-1:SSU_BW]},
                                   i_avs_writedata, i_avs_byteenable);
                next_dest_operand_reg[SSU_DW-1:SSU_BW] = m_word[SSU_HI_W-1:0];
            end else if (i_avs_address == SSU_A_ALT_LO) begin
                next_alt_operand_reg[SSU_BW-1:0] = ssu_merge(
                    alt_operand_reg[SSU_BW-1:0], i_avs_writedata, i_avs_byteenable);
            end else if (i_avs_address == SSU_A_ALT_HI) begin
                m_word = ssu_merge({{(SSU_BW-SSU_HI_W){1'b0}},
                                    alt_operand_reg[SSU_DW-1:SSU_BW]},
                                   i_avs_writedata, i_avs_byteenable);
                next_alt_operand_reg[SSU_DW-1:SSU_BW] = m_word[SSU_HI_W-1:0];
            end else if (i_avs_address == SSU_A_INDEX) begin
                m_word = ssu_merge({{(SSU_BW-IDX_W){1'b0}}, index_count_reg},
                                   i_avs_writedata, i_avs_byteenable);
                next_index_count_reg = m_word[IDX_W-1:0];
            end else if (i_avs_address == SSU_A_CTRL) begin
                go_cmd = i_avs_byteenable[0] & i_avs_writedata[SSU_CTRL_GO];
            end else if (i_avs_address == SSU_A_STAT) begin
                if (i_avs_byteenable[0] & i_avs_writedata[SSU_ST_DONE]) begin
                    next_done = 1'b0;
                end
            end
        end
        case (state)
            SSU_IDLE: begin
                if (go_cmd) begin
                    next_hold = pre;
                    next_comp_flag = is_mask | op_neg;
                    next_lcs_flag = go_left;
                    next_over_flag = over;
                    next_sel1 = SSU_SEL_ONE << cnt[1:0];
                    next_sel2 = SSU_SEL_ONE << cnt[3:2];
                    next_sel3 = over ? '0 : (SSU_SEL_ONE << cnt[5:4]);
                    next_state = SSU_SHIFT;
                end
            end
            SSU_SHIFT: begin
                next_dest_operand_reg = result;
                next_done = 1'b1;
                next_state = SSU_IDLE;
            end
            default: begin
                next_state = SSU_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= SSU_IDLE;
            instr_word_reg <= '0;
            dest_operand_reg <= '0;
            alt_operand_reg <= '0;
            index_count_reg <= '0;
            hold <= '0;
            comp_flag <= 1'b0;
            lcs_flag <= 1'b0;
            over_flag <= 1'b0;
            sel1 <= '0;
            sel2 <= '0;
            sel3 <= '0;
            done <= 1'b0;
            rd_ack <= 1'b0;
            rd_data <= '0;
        end else if (i_clk_en) begin
            state <= next_state;
            instr_word_reg <= next_instr_word_reg;
            dest_operand_reg <= next_dest_operand_reg;
            alt_operand_reg <= next_alt_operand_reg;
            index_count_reg <= next_index_count_reg;
            hold <= next_hold;
            comp_flag <= next_comp_flag;
            lcs_flag <= next_lcs_flag;
            over_flag <= next_over_flag;
            sel1 <= next_sel1;
            sel2 <= next_sel2;
            sel3 <= next_sel3;
            done <= next_done;
            rd_ack <= next_rd_ack;
            rd_data <= next_rd_data;
        end
    end
endmodule

`default_nettype wire

// ### ssu_ref_pkg.sv
// reference shift helpers for the checker and the bench
`default_nettype none
package ssu_ref_pkg;
    import ssu_pkg::*;
    function automatic logic [SSU_DW-1:0] ref_rotl(input logic [SSU_DW-1:0] v, input int n);
        int s;
        s = n % SSU_DW;
        return (v << s) | (v >> (SSU_DW - s));
    endfunction
    function automatic logic [SSU_DW-1:0] ref_sra(input logic [SSU_DW-1:0] v, input int n);
        logic signed [SSU_DW-1:0] sv;
        sv = v;
        return sv >>> n;
    endfunction
endpackage
`default_nettype wire

// ### ssu_unit_properties.sv
// concurrent checks on the shift unit ports
`default_nettype none
module ssu_unit_properties
    import ssu_pkg::*;
    import ssu_ref_pkg::*;
#(
    parameter int IDX_W = SSU_IDX_W_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [SSU_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [SSU_BW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [SSU_BW-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [SSU_DW-1:0] o_result,
    input wire logic o_busy
);
    logic [SSU_IW-1:0] instr;
    logic [SSU_IW-1:0] next_instr;
    logic wr_ok;
    logic [5:0] jk;
    logic [SSU_DW-1:0] ones;
    assign wr_ok = i_avs_write && !o_avs_waitrequest && i_clk_en;
    assign jk = instr[5:0];
    assign ones = '1;
    // shadow of the instruction word
    always_comb begin
        next_instr = instr;
        if (wr_ok && i_avs_address == SSU_A_INSTR && i_avs_byteenable[0])
            next_instr[7:0] = i_avs_writedata[7:0];
        if (wr_ok && i_avs_address == SSU_A_INSTR && i_avs_byteenable[1])
            next_instr[14:8] = i_avs_writedata[14:8];
    end
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            instr <= '0;
        else
            instr <= next_instr;
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    go_starts_busy_a:
        assert property (wr_ok && i_avs_address == SSU_A_CTRL && i_avs_writedata[0] |=> o_busy)
        else $error("go write did not start a shift");
    busy_single_a:
        assert property (o_busy && i_clk_en |=> !o_busy)
        else $error("shift took more than one busy cycle");
    result_hold_a:
        assert property (!o_busy && !(wr_ok && (i_avs_address == SSU_A_DEST_LO
            || i_avs_address == SSU_A_DEST_HI)) |=> $stable(o_result))
        else $error("result changed without go or write");
    mask_form_a:
        assert property (o_busy && i_clk_en && !instr[SSU_F_LSB + SSU_F_MID]
            |=> o_result == ~(ones >> jk))
        else $error("mask result wrong");
    left_rot_a:
        assert property (o_busy && i_clk_en && instr[14:9] == 6'h10
            |=> o_result == ref_rotl($past(o_result), jk))
        else $error("left circular result wrong");
    right_arith_a:
        assert property (o_busy && i_clk_en && instr[14:9] == 6'h11
            |=> o_result == ref_sra($past(o_result), jk))
        else $error("right shift result wrong");
    read_wait_a:
        assert property ($rose(i_avs_read) && i_clk_en |-> o_avs_waitrequest
            ##1 o_avs_waitrequest == !i_clk_en)
        else $error("read wait state count wrong");
    busy_stall_a:
        assert property (o_busy && i_avs_write |-> o_avs_waitrequest)
        else $error("write accepted while busy");
    cover property (o_busy && !instr[13]);
    cover property (o_busy && instr[14:9] == 6'h10);
    cover property (o_busy && instr[14:9] == 6'h13);
    cover property (o_busy && i_avs_write);
endmodule

bind ssu_unit ssu_unit_properties #(.IDX_W(IDX_W)) u_props (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_result(o_result),
    .o_busy(o_busy)
);
`default_nettype wire

// ### ssu_issue_model.sv
// avalon master model of the instruction issue side
`default_nettype none
module ssu_issue_model
    import ssu_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_avs_waitrequest,
    input wire logic [SSU_BW-1:0] i_avs_readdata,
    output logic [SSU_AW-1:0] o_avs_address,
    output logic o_avs_read,
    output logic o_avs_write,
    output logic [SSU_BW-1:0] o_avs_writedata
);
    initial begin
        o_avs_address = '0;
        o_avs_read = 1'b0;
        o_avs_write = 1'b0;
        o_avs_writedata = '0;
    end
    // released bus shows the inverse of the last values
    task automatic wr(input logic [SSU_AW-1:0] a, input logic [SSU_BW-1:0] d);
        @(posedge i_core_clk);
        o_avs_address <= a;
        o_avs_writedata <= d;
        o_avs_write <= 1'b1;
        @(posedge i_core_clk);
        while (i_avs_waitrequest) @(posedge i_core_clk);
        o_avs_write <= 1'b0;
        o_avs_address <= ~a;
        o_avs_writedata <= ~d;
    endtask
    task automatic rd(input logic [SSU_AW-1:0] a, output logic [SSU_BW-1:0] d);
        @(posedge i_core_clk);
        o_avs_address <= a;
        o_avs_read <= 1'b1;
        @(posedge i_core_clk);
        while (i_avs_waitrequest) @(posedge i_core_clk);
        d = i_avs_readdata;
        o_avs_read <= 1'b0;
        o_avs_address <= ~a;
    endtask
endmodule
`default_nettype wire

// ### ssu_unit_tb_top.sv
// self-checking bench of the shift unit
`default_nettype none
module ssu_unit_tb_top
    import ssu_pkg::*;
    import ssu_ref_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int IDX_W = SSU_IDX_W_DEF;
    localparam logic [SSU_DW-1:0] DV = 60'h5a3c0f96e1872d4;
    localparam logic [SSU_DW-1:0] AV = 60'hc123456789abcde;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [SSU_AW-1:0] addr;
    logic rd;
    logic wr;
    logic [SSU_BW-1:0] wdata;
    logic [SSU_BW-1:0] rdata;
    logic wait_req;
    logic [SSU_DW-1:0] result;
    logic busy;
    logic ce = 1'b1;
    int err_count = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    // clock enable drops now and then to stretch busy and bus waits
    always @(posedge clk) ce <= |3'($urandom);
    ssu_unit #(.IDX_W(IDX_W)) uut (
        .i_core_clk(clk),
        .i_reset_n(rst_n),
        .i_clk_en(ce),
        .i_avs_address(addr),
        .i_avs_read(rd),
        .i_avs_write(wr),
        .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req),
        .o_result(result),
        .o_busy(busy)
    );
    ssu_issue_model bfm (
        .i_core_clk(clk),
        .i_avs_waitrequest(wait_req),
        .i_avs_readdata(rdata),
        .o_avs_address(addr),
        .o_avs_read(rd),
        .o_avs_write(wr),
        .o_avs_writedata(wdata)
    );
    task automatic check(input string what, input logic [SSU_DW-1:0] seen,
        input logic [SSU_DW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [SSU_IW-1:0] mk(input logic [2:0] f, input logic [2:0] m,
        input logic [5:0] jk);
        return {f, m, 3'h0, jk};
    endfunction
    function automatic logic [SSU_DW-1:0] expect_res(input logic [SSU_IW-1:0] ins,
        input logic [SSU_DW-1:0] dst, input logic [SSU_DW-1:0] alt, input logic [IDX_W-1:0] idx);
        logic [SSU_DW-1:0] op;
        logic [5:0] c;
        logic [5:0] nc;
        logic [IDX_W-1:0] ni;
        op = ins[10] ? alt : dst;
        c = idx[5:0];
        nc = ~c;
        ni = ~idx;
        if (!ins[13]) return ~({SSU_DW{1'b1}} >> ins[5:0]);
        case (ins[10:9])
            2'h0: return ref_rotl(op, ins[5:0]);
            2'h1: return ref_sra(op, ins[5:0]);
            2'h2: return !idx[IDX_W-1] ? ref_rotl(op, c)
                : (|ni[IDX_W-1:6] ? '0 : ref_sra(op, nc));
            default: return idx[IDX_W-1] ? ref_rotl(op, nc)
                : (|idx[IDX_W-1:6] ? '0 : ref_sra(op, c));
        endcase
    endfunction
    task automatic run_op(input logic [SSU_IW-1:0] ins, input logic [SSU_DW-1:0] dst,
        input logic [SSU_DW-1:0] alt, input logic [IDX_W-1:0] idx);
        logic [SSU_DW-1:0] e;
        logic [SSU_BW-1:0] d;
        int n;
        e = expect_res(ins, dst, alt, idx);
        bfm.wr(SSU_A_INSTR, 32'(ins));
        bfm.wr(SSU_A_DEST_LO, dst[31:0]);
        bfm.wr(SSU_A_DEST_HI, 32'(dst[59:32]));
        bfm.wr(SSU_A_ALT_LO, alt[31:0]);
        bfm.wr(SSU_A_ALT_HI, 32'(alt[59:32]));
        bfm.wr(SSU_A_INDEX, 32'(idx));
        bfm.wr(SSU_A_STAT, 32'h00000002);
        bfm.wr(SSU_A_CTRL, 32'h00000001);
        // unmapped write right behind go stalls while the shift is frozen
        bfm.wr(8'h40, 32'h00000000);
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("busy", busy, 1'b0);
        check("result", result, e);
        bfm.rd(SSU_A_STAT, d);
        check("done", d[SSU_ST_DONE], 1'b1);
        bfm.rd(SSU_A_DEST_HI, d);
        check("dest_hi", d, {4'h0, e[59:32]});
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [SSU_BW-1:0] d;
        logic [2:0] f;
        r = $urandom(32'h3f38);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bfm.rd(8'h40, d);
        check("unmapped", d, 32'h00000000);
        bfm.rd(SSU_A_CTRL, d);
        check("ctrl_read", d, 32'h00000000);
        $display("register map test done");
        run_op(mk(3'h2, 3'h0, 6'h00), DV, AV, '0);
        run_op(mk(3'h2, 3'h0, 6'h3f), DV, AV, '0);
        run_op(mk(3'h2, 3'h1, 6'h3f), DV, AV, '0);
        run_op(mk(3'h2, 3'h5, 6'h3c), AV, DV, '0);
        run_op(mk(3'h4, 3'h0, 6'h00), DV, AV, '0);
        run_op(mk(3'h0, 3'h2, 6'h3f), DV, AV, '0);
        run_op(mk(3'h2, 3'h2, 6'h00), DV, AV, 18'h3ffbf);
        run_op(mk(3'h2, 3'h2, 6'h00), DV, AV, 18'h3ffc0);
        run_op(mk(3'h2, 3'h3, 6'h00), DV, AV, 18'h00040);
        run_op(mk(3'h2, 3'h3, 6'h00), DV, AV, 18'h3fffa);
        run_op(mk(3'h2, 3'h2, 6'h00), DV, AV, 18'h0003b);
        $display("corner test done");
        for (int i = 0; i < 200; i++) begin
            r = $urandom;
            f = r[0] ? 3'h2 : (r[3:1] & 3'h5);
            run_op(mk(f, r[6:4], r[12:7]), SSU_DW'({$urandom, $urandom}),
                SSU_DW'({$urandom, $urandom}),
                r[13] ? IDX_W'($urandom) : {{(IDX_W-8){r[14]}}, r[22:15]});
        end
        $display("random test done");
        close_out();
    end
endmodule
`default_nettype wire
